//--- src/cpuir_pkg.sv
// shared constants and carriers for the indirect-move and return block
package cpuir_pkg;
    localparam int PC_W = 15;
    localparam int PTR_W = 16;
    localparam int DATA_W = 8;
    localparam int BUS_AW = 4;

    localparam logic [BUS_AW-1:0] OFF_ACC     = 4'h0;
    localparam logic [BUS_AW-1:0] OFF_OPTION  = 4'h1;
    localparam logic [BUS_AW-1:0] OFF_STATUS  = 4'h2;
    localparam logic [BUS_AW-1:0] OFF_PWRCTL  = 4'h3;
    localparam logic [BUS_AW-1:0] OFF_INTCTL  = 4'h4;
    localparam logic [BUS_AW-1:0] OFF_PTR0_LO = 4'h5;
    localparam logic [BUS_AW-1:0] OFF_PTR0_HI = 4'h6;
    localparam logic [BUS_AW-1:0] OFF_PTR1_LO = 4'h7;
    localparam logic [BUS_AW-1:0] OFF_PTR1_HI = 4'h8;
    localparam logic [BUS_AW-1:0] OFF_PC_LO   = 4'h9;
    localparam logic [BUS_AW-1:0] OFF_PC_HI   = 4'hA;
    localparam logic [BUS_AW-1:0] OFF_STKPTR  = 4'hB;

    localparam int STATUS_C_BIT   = 0;
    localparam int STATUS_Z_BIT   = 2;
    localparam int PWRCTL_RI_BIT  = 2;
    localparam int INTCTL_IE_BIT  = 7;

    localparam logic [DATA_W-1:0] RST_ACC    = 8'h00;
    localparam logic [DATA_W-1:0] RST_OPTION = 8'hFF;
    localparam logic [DATA_W-1:0] RST_INTCTL = 8'h00;
    localparam logic [PTR_W-1:0]  RST_PTR    = 16'h0000;
    localparam logic [PC_W-1:0]   RST_PC     = 15'h0000;
    localparam logic              RST_RI     = 1'b1;

    localparam logic [PTR_W-1:0]  PTR_STEP   = 16'h0001;

    typedef enum logic [1:0] {
        MODE_PREINC  = 2'h0,
        MODE_PREDEC  = 2'h1,
        MODE_POSTINC = 2'h2,
        MODE_POSTDEC = 2'h3
    } cpuir_mode_t;

    typedef enum logic [3:0] {
        OP_NOP    = 4'h0,
        OP_OPTION = 4'h1,
        OP_RESET  = 4'h2,
        OP_RETINT = 4'h3,
        OP_RETURN = 4'h4,
        OP_LDIND  = 4'h5,
        OP_STIND  = 4'h6,
        OP_CALL   = 4'h7
    } cpuir_op_t;

    typedef enum logic [0:0] {ST_RUN, ST_SECOND} cpuir_fsm_t;

    typedef struct packed {
        cpuir_op_t         op;
        logic              ptrSel;
        cpuir_mode_t       mode;
        logic [PC_W-1:0]   target;
    } cpuir_cmd_t;

    typedef struct packed {
        logic [BUS_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wrStb;
        logic              rdStb;
    } cpuir_bus_t;
endpackage

//--- src/cpuir_mem.sv
// single-port memory with registered read data
`timescale 1ns/1ps
module cpuir_mem #(
    parameter int DW = 8,
    parameter int AW = 8
) (
    input  wire logic          ref_clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    if (AW < 1 || DW < 1) begin : g_bad_geometry
        $error("cpuir_mem: bad geometry");
    end

    // read-before-write: a same-cycle write shows up on the next read only
    always_ff @(posedge ref_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule // cpuir_mem

//--- src/cpuir_core.sv
// indirect move, option load, software reset and return execution
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module cpuir_core import cpuir_pkg::*; #(
    parameter int DMEM_AW     = 8,
    parameter int STACK_DEPTH = 16
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              cmdValid,
    input  wire cpuir_cmd_t        cmdIn,
    output logic                   cmdReady,
    input  wire cpuir_bus_t        busIn,
    output logic      [DATA_W-1:0] rdData,
    output logic      [PC_W-1:0]   progCounter,
    output logic                   globalIntEnable
);
    localparam int SP_W = $clog2(STACK_DEPTH);

    if (DMEM_AW < 1 || DMEM_AW > PTR_W) begin : g_bad_aw
        $error("cpuir_core: DMEM_AW out of range");
    end
    if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_bad_depth
        $error("cpuir_core: STACK_DEPTH must be a power of two");
    end

    typedef struct packed {
        cpuir_fsm_t        state;
        logic              ready;
        cpuir_op_t         op;
        logic [PC_W-1:0]   pc;
        logic [DATA_W-1:0] w;
        logic [DATA_W-1:0] option;
        logic [DATA_W-1:0] intctl;
        logic              z;
        logic              c;
        logic              ri;
        logic [PTR_W-1:0]  ptr0;
        logic [PTR_W-1:0]  ptr1;
        logic [SP_W-1:0]   sp;
        logic [DATA_W-1:0] rdData;
    } cpuir_state_t;

    localparam cpuir_state_t RESET_STATE = '{
        state: ST_RUN, ready: 1'b1, op: OP_NOP, pc: RST_PC, w: RST_ACC,
        option: RST_OPTION, intctl: RST_INTCTL, z: 1'b0, c: 1'b0, ri: RST_RI,
        ptr0: RST_PTR, ptr1: RST_PTR, sp: '0, rdData: '0
    };

    cpuir_state_t s_q, s_d;

    logic              memWe, stkWe;
    logic [DMEM_AW-1:0] memAddr;
    logic [DATA_W-1:0] memWdata, memRdata;
    logic [SP_W-1:0]   stkAddr;
    logic [PC_W-1:0]   stkWdata, stkRdata;

    // 16-bit arithmetic drops the carry, so the pointer wraps by itself
    function automatic logic [PTR_W-1:0] ptrStep(logic [PTR_W-1:0] p, cpuir_mode_t m);
        if (m == MODE_PREINC || m == MODE_POSTINC) return p + PTR_STEP;
        return p - PTR_STEP;
    endfunction

    function automatic logic [PTR_W-1:0] effAddr(logic [PTR_W-1:0] p, cpuir_mode_t m);
        if (m == MODE_PREINC || m == MODE_PREDEC) return ptrStep(p, m);
        return p;
    endfunction

    function automatic logic [DATA_W-1:0] regRead(cpuir_state_t s, logic [BUS_AW-1:0] a);
        logic [DATA_W-1:0] v;
        v = '0;
        case (a)
            OFF_ACC:     v = s.w;
            OFF_OPTION:  v = s.option;
            OFF_STATUS: begin
                v[STATUS_Z_BIT] = s.z;
                v[STATUS_C_BIT] = s.c;
            end
            OFF_PWRCTL:  v[PWRCTL_RI_BIT] = s.ri;
            OFF_INTCTL:  v = s.intctl;
            OFF_PTR0_LO: v = s.ptr0[7:0];
            OFF_PTR0_HI: v = s.ptr0[15:8];
            OFF_PTR1_LO: v = s.ptr1[7:0];
            OFF_PTR1_HI: v = s.ptr1[15:8];
            OFF_PC_LO:   v = s.pc[7:0];
            OFF_PC_HI:   v = {1'b0, s.pc[14:8]};
            OFF_STKPTR:  v[SP_W-1:0] = s.sp;
            default:     v = '0;
        endcase
        return v;
    endfunction

    always_comb begin
        logic [PTR_W-1:0] ptr;
        ptr      = cmdIn.ptrSel ? s_q.ptr1 : s_q.ptr0;
        s_d      = s_q;
        memWe    = 1'b0;
        memAddr  = '0;
        memWdata = s_q.w;
        stkWe    = 1'b0;
        stkAddr  = s_q.sp;
        stkWdata = s_q.pc + 1'b1;
        s_d.rdData = busIn.rdStb ? regRead(s_q, busIn.addr) : '0;
        // bus writes land first so a same-cycle instruction overrides them
        if (busIn.wrStb) begin
            case (busIn.addr)
                OFF_ACC:     s_d.w = busIn.wdata;
                OFF_OPTION:  s_d.option = busIn.wdata;
                OFF_STATUS: begin
                    s_d.z = busIn.wdata[STATUS_Z_BIT];
                    s_d.c = busIn.wdata[STATUS_C_BIT];
                end
                OFF_PWRCTL:  s_d.ri = busIn.wdata[PWRCTL_RI_BIT];
                OFF_INTCTL:  s_d.intctl = busIn.wdata;
                OFF_PTR0_LO: s_d.ptr0[7:0] = busIn.wdata;
                OFF_PTR0_HI: s_d.ptr0[15:8] = busIn.wdata;
                OFF_PTR1_LO: s_d.ptr1[7:0] = busIn.wdata;
                OFF_PTR1_HI: s_d.ptr1[15:8] = busIn.wdata;
                OFF_PC_LO:   s_d.pc[7:0] = busIn.wdata;
                OFF_PC_HI:   s_d.pc[14:8] = busIn.wdata[6:0];
                OFF_STKPTR:  s_d.sp = busIn.wdata[SP_W-1:0];
                default: ;
            endcase
        end
        case (s_q.state)
            ST_RUN: begin
                if (cmdValid) begin
                    s_d.pc = s_q.pc + 1'b1;
                    case (cmdIn.op)
                        OP_NOP: ;
                        OP_OPTION: s_d.option = s_q.w;
                        OP_RESET: begin
                            s_d = RESET_STATE;
                            s_d.ri = 1'b0;
                        end
                        OP_STIND, OP_LDIND: begin
                            // flags z and c are not touched by the step
                            memAddr = DMEM_AW'(effAddr(ptr, cmdIn.mode));
                            memWe = (cmdIn.op == OP_STIND);
                            if (cmdIn.ptrSel) s_d.ptr1 = ptrStep(ptr, cmdIn.mode);
                            else s_d.ptr0 = ptrStep(ptr, cmdIn.mode);
                            if (cmdIn.op == OP_LDIND) begin
                                s_d.state = ST_SECOND;
                                s_d.op = cmdIn.op;
                            end
                        end
                        OP_CALL: begin
                            stkWe = 1'b1;
                            s_d.sp = s_q.sp + 1'b1;
                            s_d.pc = cmdIn.target;
                        end
                        OP_RETINT, OP_RETURN: begin
                            // pop address issued now, data arrives next cycle
                            stkAddr = s_q.sp - 1'b1;
                            s_d.sp = s_q.sp - 1'b1;
                            s_d.pc = s_q.pc;
                            s_d.state = ST_SECOND;
                            s_d.op = cmdIn.op;
                        end
                        default: ;
                    endcase
                end
            end
            ST_SECOND: begin
                s_d.state = ST_RUN;
                case (s_q.op)
                    OP_LDIND: begin
                        s_d.w = memRdata;
                        s_d.z = (memRdata == '0);
                    end
                    OP_RETINT: begin
                        s_d.pc = stkRdata;
                        s_d.intctl[INTCTL_IE_BIT] = 1'b1;
                    end
                    OP_RETURN: s_d.pc = stkRdata;
                    default: ;
                endcase
            end
            default: s_d.state = ST_RUN;
        endcase
        s_d.ready = (s_d.state == ST_RUN);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) s_q <= RESET_STATE;
        else s_q <= s_d;
    end

    cpuir_mem #(.DW(DATA_W), .AW(DMEM_AW)) u_dmem (
        .ref_clk (ref_clk),
        .we      (memWe),
        .addr    (memAddr),
        .wdata   (memWdata),
        .rdata   (memRdata)
    );

    cpuir_mem #(.DW(PC_W), .AW(SP_W)) u_stack (
        .ref_clk (ref_clk),
        .we      (stkWe),
        .addr    (stkAddr),
        .wdata   (stkWdata),
        .rdata   (stkRdata)
    );

    assign cmdReady        = s_q.ready;
    assign rdData          = s_q.rdData;
    assign progCounter     = s_q.pc;
    assign globalIntEnable = s_q.intctl[INTCTL_IE_BIT];

    logic acc;
    assign acc = cmdValid && s_q.ready && !busIn.wrStb;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_popWait;
        !s_q.ready;
    endsequence

    property p_preinc_wrap;
        acc && cmdIn.op == OP_STIND && !cmdIn.ptrSel && cmdIn.mode == MODE_PREINC
        && s_q.ptr0 == 16'hFFFF |=> s_q.ptr0 == 16'h0000;
    endproperty
    a_preinc_wrap: assert property (p_preinc_wrap)
        else $error("pre-inc did not wrap");

    property p_predec_wrap;
        acc && cmdIn.op == OP_LDIND && cmdIn.ptrSel && cmdIn.mode == MODE_PREDEC
        && s_q.ptr1 == 16'h0000 |-> memAddr == '1 ##1 s_q.ptr1 == 16'hFFFF;
    endproperty
    a_predec_wrap: assert property (p_predec_wrap)
        else $error("pre-dec wrong");

    property p_post_addr;
        acc && cmdIn.op == OP_STIND && !cmdIn.ptrSel && cmdIn.mode == MODE_POSTDEC
        |-> memWe && memAddr == s_q.ptr0[DMEM_AW-1:0] ##1 s_q.ptr0 == $past(s_q.ptr0) - 1'b1;
    endproperty
    a_post_addr: assert property (p_post_addr)
        else $error("post-dec address wrong");

    property p_read_port;
        acc && cmdIn.op == OP_LDIND |=> s_popWait ##1 s_q.w == $past(memRdata) && s_q.ready;
    endproperty
    a_read_port: assert property (p_read_port) else $error("indirect read wrong");

    // z only moves on the data cycle of a load, so both flags hold at the step edge
    property p_flags_kept;
        acc && (cmdIn.op == OP_STIND || cmdIn.op == OP_LDIND)
        |=> $stable(s_q.c) && $stable(s_q.z);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flag changed by step");

    property p_nop;
        acc && cmdIn.op == OP_NOP |=> s_q.pc == $past(s_q.pc) + 1'b1 && $stable(s_q.w)
        && $stable(s_q.ptr0) && $stable(s_q.ptr1) && $stable(s_q.z) && s_q.ready;
    endproperty
    a_nop: assert property (p_nop) else $error("nop changed state");

    property p_option;
        acc && cmdIn.op == OP_OPTION |=> s_q.option == $past(s_q.w) && $stable(s_q.w)
        && $stable(s_q.z) && s_q.ready;
    endproperty
    a_option: assert property (p_option) else $error("option load wrong");

    property p_swreset;
        cmdValid && s_q.ready && cmdIn.op == OP_RESET |=> !s_q.ri && s_q.pc == RST_PC
        && s_q.option == RST_OPTION && s_q.ptr0 == RST_PTR && s_q.sp == '0;
    endproperty
    a_swreset: assert property (p_swreset) else $error("software reset wrong");

    property p_ret_int;
        acc && cmdIn.op == OP_RETINT |=> s_popWait ##1
        s_q.pc == $past(stkRdata) && globalIntEnable && s_q.ready;
    endproperty
    a_ret_int: assert property (p_ret_int)
        else $error("interrupt return wrong");

    property p_return;
        acc && cmdIn.op == OP_RETURN ##1 !busIn.wrStb |=>
        s_q.pc == $past(stkRdata) && globalIntEnable == $past(globalIntEnable, 2)
        && s_q.z == $past(s_q.z, 2);
    endproperty
    a_return: assert property (p_return) else $error("subroutine return wrong");
endmodule // cpuir_core

//--- testbench/cpuir_core_tb.sv
// self-checking bench for the indirect-move and return block
`timescale 1ns/1ps
module cpuir_core_tb import cpuir_pkg::*;;
    logic              ref_clk;
    logic              rst_n;
    logic              cmdValid;
    cpuir_cmd_t        cmdIn;
    logic              cmdReady;
    cpuir_bus_t        busIn;
    logic [DATA_W-1:0] rdData;
    logic [PC_W-1:0]   progCounter;
    logic              globalIntEnable;
    int                errTotal;
    int                nTests;
    logic [PC_W-1:0]   pcSave;

    cpuir_core cpuir_core_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdIn(cmdIn),
        .cmdReady(cmdReady), .busIn(busIn), .rdData(rdData),
        .progCounter(progCounter), .globalIntEnable(globalIntEnable)
    );

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        nTests++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [BUS_AW-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        busIn <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        busIn <= '0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [BUS_AW-1:0] a, input logic [DATA_W-1:0] exp,
                      input string what, input logic [DATA_W-1:0] m = 8'hFF);
        @(posedge ref_clk);
        busIn <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        busIn <= '0;
        #1;
        chk(16'(rdData & m), 16'(exp), what);
    endtask

    // extra counts the edges spent with cmdReady low after the take
    task automatic op(input cpuir_op_t o, input logic s, input cpuir_mode_t md,
                      input logic [PC_W-1:0] t, input int extra);
        int n;
        n = 0;
        @(posedge ref_clk);
        cmdValid <= 1'b1;
        cmdIn    <= '{o, s, md, t};
        @(posedge ref_clk);
        cmdValid <= 1'b0;
        #1;
        while (cmdReady !== 1'b1 && n < 8) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n < 8) begin
            chk(16'(n), 16'(extra), "instruction cycles");
        end else begin
            errTotal++;
            $display("ERROR %0t instruction never completed", $time);
            results();
        end
    endtask

    task automatic t_reset_values();
        chk(16'(progCounter), 16'h0000, "pc after reset");
        chk(16'(globalIntEnable), 16'h0000, "enable after reset");
        rd(OFF_OPTION, 8'hFF, "option after reset");
        rd(OFF_PWRCTL, 8'h04, "reset flag after reset", 8'h04);
        wr(4'hC, 8'h5A);
        rd(4'hC, 8'h00, "unmapped read");
        $display("test reset_values done");
    endtask

    task automatic t_nop();
        wr(OFF_ACC, 8'h3C);
        wr(OFF_STATUS, 8'h01);
        pcSave = progCounter;
        op(OP_NOP, 1'b0, MODE_PREINC, 15'h0000, 0);
        chk(16'(progCounter), 16'(pcSave + 15'h0001), "pc after nop");
        rd(OFF_ACC, 8'h3C, "acc after nop");
        rd(OFF_STATUS, 8'h01, "status after nop", 8'h05);
        rd(OFF_OPTION, 8'hFF, "option after nop");
        $display("test nop done");
    endtask

    task automatic t_option();
        wr(OFF_ACC, 8'h4F);
        wr(OFF_STATUS, 8'h04);
        op(OP_OPTION, 1'b0, MODE_PREINC, 15'h0000, 0);
        rd(OFF_OPTION, 8'h4F, "option load");
        rd(OFF_ACC, 8'h4F, "acc after option");
        rd(OFF_STATUS, 8'h04, "status after option", 8'h05);
        $display("test option done");
    endtask

    // every mode from pointer 0080 on pointer 1, then read back through the port
    task automatic t_modes();
        logic [7:0] adr [4];
        logic [7:0] aft [4];
        adr = '{8'h81, 8'h7F, 8'h80, 8'h80};
        aft = '{8'h81, 8'h7F, 8'h81, 8'h7F};
        for (int i = 0; i < 4; i++) begin
            wr(OFF_PTR1_LO, 8'h80);
            wr(OFF_PTR1_HI, 8'h00);
            wr(OFF_ACC, 8'(16 + i));
            wr(OFF_STATUS, 8'h05);
            op(OP_STIND, 1'b1, cpuir_mode_t'(i), 15'h0000, 0);
            rd(OFF_PTR1_LO, aft[i], "pointer after move");
            rd(OFF_STATUS, 8'h05, "status after step", 8'h05);
            wr(OFF_ACC, 8'h00);
            wr(OFF_PTR1_LO, adr[i] - 8'h01);
            op(OP_LDIND, 1'b1, MODE_PREINC, 15'h0000, 1);
            rd(OFF_ACC, 8'(16 + i), "data at pointer");
            rd(OFF_STATUS, 8'h01, "carry after read step", 8'h01);
        end
        $display("test modes done");
    endtask

    task automatic t_wrap();
        wr(OFF_PTR0_LO, 8'hFF);
        wr(OFF_PTR0_HI, 8'hFF);
        wr(OFF_ACC, 8'h5A);
        op(OP_STIND, 1'b0, MODE_PREINC, 15'h0000, 0);
        rd(OFF_PTR0_LO, 8'h00, "wrap up low");
        rd(OFF_PTR0_HI, 8'h00, "wrap up high");
        wr(OFF_ACC, 8'h00);
        op(OP_LDIND, 1'b0, MODE_POSTDEC, 15'h0000, 1);
        rd(OFF_PTR0_LO, 8'hFF, "wrap down low");
        rd(OFF_PTR0_HI, 8'hFF, "wrap down high");
        rd(OFF_ACC, 8'h5A, "data at wrapped address");
        // store at the wrapped top byte, then reach it by stepping pointer 1 below zero
        wr(OFF_ACC, 8'hA5);
        op(OP_STIND, 1'b0, MODE_POSTDEC, 15'h0000, 0);
        rd(OFF_PTR0_LO, 8'hFE, "post-dec after store");
        wr(OFF_PTR1_LO, 8'h00);
        wr(OFF_PTR1_HI, 8'h00);
        wr(OFF_ACC, 8'h00);
        op(OP_LDIND, 1'b1, MODE_PREDEC, 15'h0000, 1);
        rd(OFF_ACC, 8'hA5, "data below zero");
        rd(OFF_PTR1_HI, 8'hFF, "wrap down pointer 1");
        $display("test wrap done");
    endtask

    task automatic t_returns();
        wr(OFF_INTCTL, 8'h00);
        pcSave = progCounter;
        op(OP_CALL, 1'b0, MODE_PREINC, 15'h1234, 0);
        chk(16'(progCounter), 16'h1234, "call target");
        rd(OFF_PC_LO, 8'h34, "pc low byte");
        rd(OFF_PC_HI, 8'h12, "pc high byte");
        rd(OFF_STKPTR, 8'h01, "stack pointer after call");
        op(OP_RETINT, 1'b0, MODE_PREINC, 15'h0000, 1);
        chk(16'(progCounter), 16'(pcSave + 15'h0001), "pc after interrupt return");
        chk(16'(globalIntEnable), 16'h0001, "enable set");
        rd(OFF_INTCTL, 8'h80, "enable bit 7", 8'h80);
        rd(OFF_STKPTR, 8'h00, "stack pointer after pop");
        wr(OFF_INTCTL, 8'h00);
        wr(OFF_STATUS, 8'h05);
        pcSave = progCounter;
        op(OP_CALL, 1'b0, MODE_PREINC, 15'h0ABC, 0);
        op(OP_RETURN, 1'b0, MODE_PREINC, 15'h0000, 1);
        chk(16'(progCounter), 16'(pcSave + 15'h0001), "pc after return");
        chk(16'(globalIntEnable), 16'h0000, "enable untouched");
        rd(OFF_STATUS, 8'h05, "status after return", 8'h05);
        $display("test returns done");
    endtask

    task automatic t_soft_reset();
        wr(OFF_ACC, 8'h33);
        wr(OFF_INTCTL, 8'h80);
        wr(OFF_PTR0_LO, 8'h12);
        wr(OFF_STKPTR, 8'h03);
        wr(OFF_PC_HI, 8'h7F);
        rd(OFF_PC_HI, 8'h7F, "pc high write");
        op(OP_RESET, 1'b0, MODE_PREINC, 15'h0000, 0);
        chk(16'(progCounter), 16'h0000, "pc after soft reset");
        chk(16'(globalIntEnable), 16'h0000, "enable after soft reset");
        rd(OFF_OPTION, 8'hFF, "option after soft reset");
        rd(OFF_ACC, 8'h00, "acc after soft reset");
        rd(OFF_PTR0_LO, 8'h00, "pointer after soft reset");
        rd(OFF_PWRCTL, 8'h00, "reset flag cleared", 8'h04);
        rd(OFF_STKPTR, 8'h00, "stack pointer after soft reset");
        // a pin reset in mid-run must raise the cause flag again
        @(posedge ref_clk);
        rst_n <= 1'b0;
        @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(OFF_PWRCTL, 8'h04, "reset flag after pin reset", 8'h04);
        $display("test soft_reset done");
    endtask

    initial begin
        errTotal = 0;
        nTests   = 0;
        rst_n    = 1'b0;
        cmdValid = 1'b0;
        cmdIn    = '0;
        busIn    = '0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        t_reset_values();
        t_nop();
        t_option();
        t_modes();
        t_wrap();
        t_returns();
        t_soft_reset();
        results();
    end
endmodule // cpuir_core_tb
